// ===== design/serial_frame_consts.svh
// timing and field constants for the serial frame link
// included by the package and both ends; holds definitions only
`ifndef SERIAL_FRAME_CONSTS_SVH
`define SERIAL_FRAME_CONSTS_SVH

`define CLK_PERIOD_NS       100
`define FRAME_BITS          24
`define CTRL_MSB            23
`define CTRL_LSB            16
`define DATA_MSB            15
`define DATA_LSB            0
`define BIT_TOP             23
`define BIT_SECOND          22
`define LOAD_HI_BIT         21
`define LOAD_LO_BIT         20
// host timing, ns as printed
`define GAP_AFTER_LAST_NS   130
`define SYNC_HIGH_MIN_NS    50
// serial clock half period in system cycles (clock far below 20 MHz)
`define SCLK_HALF_CYC       2
`define GAP_AFTER_LAST_CYC  ((`GAP_AFTER_LAST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_HIGH_MIN_CYC   ((`SYNC_HIGH_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FIFO_DEPTH          32

`endif

// ===== design/serial_frame_pkg.sv
// types shared by both ends of the serial frame link
// assumes serial_frame_consts.svh is on the include path
`include "serial_frame_consts.svh"
package serial_frame_pkg;
  typedef logic [`FRAME_BITS-1:0] frame_word_t;
  typedef logic [`CTRL_MSB-`CTRL_LSB:0] ctrl_t;
  typedef logic [`DATA_MSB:0] data_t;
endpackage

// ===== design/serial_frame_if.sv
// three-wire serial frame link between host end and device end
// assumes both ends share clk_i; the link signals are plain wires
`timescale 1ns/1ps
interface serial_frame_if;
  logic sync_b;
  logic sclk;
  logic sdata;
  modport host_mp   (output sync_b, output sclk, output sdata);
  modport device_mp (input sync_b, input sclk, input sdata);
endinterface

// ===== design/frame_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock; full and empty derived from a fill count
`timescale 1ns/1ps
module frame_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
    $error("frame_fifo: depth must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem_q[rd_q];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== design/frame_host.sv
// host end: serialises 24-bit words from its user port onto the link
// assumes the device samples data on falling serial clock edges
`timescale 1ns/1ps
`include "serial_frame_consts.svh"
module frame_host (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_b_i,
  // user request
  input  wire logic                         req_valid_i,
  output logic                              req_ready_o,
  input  wire serial_frame_pkg::frame_word_t req_word_i,
  input  wire logic                         req_abort_i,
  // link
  serial_frame_if.host_mp                   link
);
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_HIGH = 4'b0010,
    H_LOW  = 4'b0100,
    H_GAP  = 4'b1000
  } hstate_t;

  localparam int GAP_CYC  = (`GAP_AFTER_LAST_CYC > `SYNC_HIGH_MIN_CYC) ?
                            `GAP_AFTER_LAST_CYC : `SYNC_HIGH_MIN_CYC;
  hstate_t                       st_q;
  serial_frame_pkg::frame_word_t sh_q;
  logic [4:0]                    bits_q;
  logic [3:0]                    tmr_q;
  logic                          sync_b_q;
  logic                          sclk_q;

  assign req_ready_o = (st_q == H_IDLE);
  assign link.sync_b = sync_b_q;
  assign link.sclk   = sclk_q;
  assign link.sdata  = sh_q[`FRAME_BITS-1];

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q     <= H_IDLE;
      sh_q     <= '0;
      bits_q   <= '0;
      tmr_q    <= '0;
      sync_b_q <= 1'b1;
      sclk_q   <= 1'b1;
    end else begin
      case (st_q)
        H_IDLE: begin
          if (req_valid_i) begin
            sh_q     <= req_word_i;
            sync_b_q <= 1'b0;
            bits_q   <= '0;
            tmr_q    <= 4'(`SCLK_HALF_CYC - 1);
            st_q     <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (tmr_q == '0) begin
            sclk_q <= 1'b0;
            bits_q <= bits_q + 5'h1;
            tmr_q  <= 4'(`SCLK_HALF_CYC - 1);
            st_q   <= H_LOW;
          end else begin
            tmr_q <= tmr_q - 4'h1;
          end
        end
        H_LOW: begin
          if (req_abort_i && bits_q != 5'(`FRAME_BITS)) begin
            sync_b_q <= 1'b1;
            sclk_q   <= 1'b1;
            tmr_q    <= 4'(GAP_CYC);
            st_q     <= H_GAP;
          end else if (tmr_q == '0) begin
            sclk_q <= 1'b1;
            sh_q   <= {sh_q[`FRAME_BITS-2:0], 1'b0};
            if (bits_q == 5'(`FRAME_BITS)) begin
              sync_b_q <= 1'b1;
              tmr_q    <= 4'(GAP_CYC);
              st_q     <= H_GAP;
            end else begin
              tmr_q <= 4'(`SCLK_HALF_CYC - 1);
              st_q  <= H_HIGH;
            end
          end else begin
            tmr_q <= tmr_q - 4'h1;
          end
        end
        H_GAP: begin
          if (tmr_q == '0) begin
            st_q <= H_IDLE;
          end else begin
            tmr_q <= tmr_q - 4'h1;
          end
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== design/frame_device.sv
// device end: receives 24-bit frames, checks address, queues commands
// assumes link pins are asynchronous to clk_i and far slower than it
`timescale 1ns/1ps
`include "serial_frame_consts.svh"
module frame_device #(
  parameter int DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  // straps and enable
  input  wire logic                   addr_pin_low_i,
  input  wire logic                   addr_pin_high_i,
  input  wire logic                   if_enable_b_i,
  // link
  serial_frame_if.device_mp           link,
  // command output
  output logic                        cmd_valid_o,
  input  wire logic                   cmd_ready_i,
  output serial_frame_pkg::ctrl_t     cmd_ctrl_o,
  output serial_frame_pkg::data_t     cmd_data_o,
  // status
  output logic                        frame_drop_o,
  output logic                        frame_abort_o
);
  typedef enum logic [2:0] {
    R_WAIT  = 3'b001,
    R_SHIFT = 3'b010,
    R_DONE  = 3'b100
  } rstate_t;

  // the queue wraps its pointers, so its depth must be a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("frame_device: fifo depth must be a power of two >= 2");
  end

  // three-stage synchronisers; stage 1 feeds only stage 2
  logic [2:0] sync_s1_q;
  logic [2:0] sync_s2_q;
  logic [2:0] sync_s3_q;
  logic [2:0] pin_q;
  logic [2:0] raw;

  // gate pins while the port is disconnected: idle sync, idle clock
  assign raw = if_enable_b_i ? 3'b110 :
               {link.sync_b, link.sclk, link.sdata};

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_s1_q <= 3'b110;
      sync_s2_q <= 3'b110;
      sync_s3_q <= 3'b110;
      pin_q     <= 3'b110;
    end else begin
      sync_s1_q <= raw;
      sync_s2_q <= sync_s1_q;
      sync_s3_q <= sync_s2_q;
      for (int i = 0; i < 3; i++) begin
        if (sync_s2_q[i] == sync_s3_q[i]) begin
          pin_q[i] <= sync_s3_q[i];
        end
      end
    end
  end

  logic sync_b_f;
  logic sclk_f;
  logic prev_sync_q;
  logic prev_sclk_q;
  logic sync_fall;
  logic sync_rise;
  logic sclk_fall;

  assign sync_b_f  = pin_q[2];
  assign sclk_f    = pin_q[1];
  assign sync_fall = prev_sync_q && !sync_b_f;
  assign sync_rise = !prev_sync_q && sync_b_f;
  assign sclk_fall = prev_sclk_q && !sclk_f;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_sync_q <= 1'b1;
      prev_sclk_q <= 1'b1;
    end else begin
      prev_sync_q <= sync_b_f;
      prev_sclk_q <= sclk_f;
    end
  end

  function automatic logic addr_hit(serial_frame_pkg::frame_word_t w,
                                    logic a_hi, logic a_lo);
    logic bcast;
    bcast    = w[`LOAD_HI_BIT] && w[`LOAD_LO_BIT];
    addr_hit = bcast || (w[`BIT_TOP] == a_hi && w[`BIT_SECOND] == a_lo);
  endfunction

  rstate_t                       st_q;
  serial_frame_pkg::frame_word_t sh_q;
  logic [4:0]                    cnt_q;
  logic                          done_q;
  logic                          fifo_ready;
  logic                          push_q;
  serial_frame_pkg::frame_word_t push_word_q;
  logic                          abort_q;
  logic                          drop_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q   <= R_WAIT;
      sh_q   <= '0;
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        R_WAIT: begin
          cnt_q <= '0;
          if (sync_fall) begin
            st_q <= R_SHIFT;
          end
        end
        R_SHIFT: begin
          if (sync_b_f) begin
            cnt_q <= '0;
            st_q  <= R_WAIT;
          end else if (sclk_fall) begin
            sh_q  <= {sh_q[`FRAME_BITS-2:0], pin_q[0]};
            cnt_q <= cnt_q + 5'h1;
            if (cnt_q == 5'(`FRAME_BITS - 1)) begin
              done_q <= 1'b1;
              st_q   <= R_DONE;
            end
          end
        end
        R_DONE: begin
          // shift register locked; more clocks ignored
          cnt_q <= '0;
          if (sync_b_f) begin
            st_q <= R_WAIT;
          end
        end
        default: begin
          st_q <= R_WAIT;
        end
      endcase
    end
  end

  // straps are pins too: three flops, taken once stages two and three agree
  logic [1:0] strap_s1_q;
  logic [1:0] strap_s2_q;
  logic [1:0] strap_s3_q;
  logic       a_hi_q;
  logic       a_lo_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      strap_s1_q <= 2'h0;
      strap_s2_q <= 2'h0;
      strap_s3_q <= 2'h0;
      a_hi_q     <= 1'b0;
      a_lo_q     <= 1'b0;
    end else begin
      strap_s1_q <= {addr_pin_high_i, addr_pin_low_i};
      strap_s2_q <= strap_s1_q;
      strap_s3_q <= strap_s2_q;
      if (strap_s2_q == strap_s3_q) begin
        a_hi_q <= strap_s3_q[1];
        a_lo_q <= strap_s3_q[0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      push_q      <= 1'b0;
      push_word_q <= '0;
      abort_q     <= 1'b0;
      drop_q      <= 1'b0;
    end else begin
      abort_q <= (st_q == R_SHIFT) && sync_b_f && (cnt_q != '0);
      drop_q  <= 1'b0;
      if (push_q && fifo_ready) begin
        push_q <= 1'b0;
      end
      if (done_q) begin
        if (addr_hit(sh_q, a_hi_q, a_lo_q)) begin
          if (push_q && !fifo_ready) begin
            drop_q <= 1'b1;    // fifo full: frame lost, reported
          end else begin
            push_q      <= 1'b1;
            push_word_q <= sh_q;
          end
        end
      end
    end
  end

  serial_frame_pkg::frame_word_t out_word;

  frame_fifo #(
    .WIDTH ($bits(serial_frame_pkg::frame_word_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (push_q),
    .in_ready_o  (fifo_ready),
    .in_data_i   (push_word_q),
    .out_valid_o (cmd_valid_o),
    .out_ready_i (cmd_ready_i),
    .out_data_o  (out_word)
  );

  // data is passed as raw unsigned code, 0..65535
  assign cmd_ctrl_o    = out_word[`CTRL_MSB:`CTRL_LSB];
  assign cmd_data_o    = out_word[`DATA_MSB:`DATA_LSB];
  assign frame_drop_o  = drop_q;
  assign frame_abort_o = abort_q;
endmodule

// ===== testbench/serial_frame_props.sv
// checker on the three link wires between host end and device end
// assumes the wires change only just after clk_i rising edges
`timescale 1ns/1ps
module serial_frame_props (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // link
  input  wire logic sync_b,
  input  wire logic sclk,
  input  wire logic sdata
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  logic [5:0] fall_q;

  // falls seen in the open frame; cleared while sync is high
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fall_q <= 6'h00;
    end else if (sync_b) begin
      fall_q <= 6'h00;
    end else if ($fell(sclk)) begin
      fall_q <= fall_q + 6'h01;
    end
  end

  sequence s_setup;
    sclk [*2] ##1 !sclk;
  endsequence

  property p_idle_clk;
    sync_b && $past(sync_b) |-> sclk;
  endproperty
  property p_setup;
    $fell(sync_b) |-> s_setup;
  endproperty
  property p_high_time;
    $rose(sclk) && !sync_b |=> sclk;
  endproperty
  property p_low_time;
    $fell(sclk) |=> !sclk || sync_b;
  endproperty
  property p_data_hold;
    !sclk |-> $stable(sdata);
  endproperty
  property p_stop_24;
    fall_q == 6'h18 && !sync_b |-> !$fell(sclk);
  endproperty
  property p_sync_gap;
    $rose(sync_b) |-> sync_b [*2];
  endproperty
  property p_sync_end;
    $rose(sync_b) |-> sclk;
  endproperty
  property p_frame_len;
    $fell(sync_b) |-> ##[1:120] sync_b;
  endproperty

  AST_IDLE_CLK_HIGH: assert property (p_idle_clk)
    else $error("serial clock low outside a frame");
  AST_SYNC_SETUP: assert property (p_setup)
    else $error("first clock fall not two cycles after sync fall");
  AST_HIGH_TIME: assert property (p_high_time)
    else $error("serial clock high phase too short");
  AST_LOW_TIME: assert property (p_low_time)
    else $error("serial clock low phase too short");
  AST_DATA_HOLD: assert property (p_data_hold)
    else $error("data moved while serial clock low");
  AST_STOP_24: assert property (p_stop_24)
    else $error("more than 24 clock falls in one frame");
  AST_SYNC_GAP: assert property (p_sync_gap)
    else $error("sync high time too short");
  AST_SYNC_END: assert property (p_sync_end)
    else $error("sync rose with serial clock low");
  AST_FRAME_LEN: assert property (p_frame_len)
    else $error("frame did not end in time");
endmodule

// ===== testbench/quad_dac_serial_frame_receiver_tb.sv
// testbench: host end and device end joined by one link
// assumes the design package and constants header are compiled first
`timescale 1ns/1ps
`include "serial_frame_consts.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  bad_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module quad_dac_serial_frame_receiver_tb;
  logic                          clk_i;
  logic                          rst_b_i;
  logic                          req_valid;
  logic                          req_ready;
  serial_frame_pkg::frame_word_t req_word;
  logic                          req_abort;
  logic                          en_b;
  logic                          cmd_valid;
  logic                          cmd_ready;
  serial_frame_pkg::ctrl_t       cmd_ctrl;
  serial_frame_pkg::data_t       cmd_data;
  logic                          drop;
  logic                          abort;
  int                            bad_count;
  int                            n_compared;
  int                            n_drop;
  int                            n_abort;
  int                            k;

  serial_frame_if lk ();
  frame_host i_frame_host (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .req_valid_i(req_valid), .req_ready_o(req_ready),
    .req_word_i(req_word), .req_abort_i(req_abort), .link(lk));
  // straps fixed at address 2'b10
  frame_device i_frame_device (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .addr_pin_low_i(1'b0), .addr_pin_high_i(1'b1),
    .if_enable_b_i(en_b), .link(lk), .cmd_valid_o(cmd_valid),
    .cmd_ready_i(cmd_ready), .cmd_ctrl_o(cmd_ctrl),
    .cmd_data_o(cmd_data), .frame_drop_o(drop), .frame_abort_o(abort));
  serial_frame_props i_serial_frame_props (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .sync_b(lk.sync_b), .sclk(lk.sclk),
    .sdata(lk.sdata));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // status outputs are one-cycle pulses, so count them at every edge
  always @(posedge clk_i) begin
    if (drop === 1'b1) n_drop++;
    if (abort === 1'b1) n_abort++;
  end

  task automatic finish_test();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wait_ready();
    int i;
    i = 0;
    do @(posedge clk_i); while (req_ready !== 1'b1 && ++i < 300);
    `CHK("ready", 1'h1, req_ready)
  endtask

  task automatic send(input serial_frame_pkg::frame_word_t w);
    wait_ready();
    req_valid <= 1'b1;
    req_word  <= w;
    @(posedge clk_i);
    req_valid <= 1'b0;
    repeat (2) @(posedge clk_i);
    wait_ready();
    repeat (8) @(posedge clk_i);
  endtask

  task automatic take(input serial_frame_pkg::ctrl_t c,
                      input serial_frame_pkg::data_t d);
    int i;
    i = 0;
    do @(posedge clk_i); while (cmd_valid !== 1'b1 && ++i < 20);
    `CHK("valid", 1'h1, cmd_valid)
    `CHK("ctrl", c, cmd_ctrl)
    `CHK("data", d, cmd_data)
    cmd_ready <= 1'b1;
    @(posedge clk_i);
    cmd_ready <= 1'b0;
  endtask

  task automatic no_cmd();
    repeat (20) @(posedge clk_i);
    `CHK("no command", 1'h0, cmd_valid)
  endtask

  initial begin
    rst_b_i   = 1'b0;
    req_valid = 1'b0;
    req_word  = 24'h00_0000;
    req_abort = 1'b0;
    en_b      = 1'b0;
    cmd_ready = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    // consumer stalls: queue fills, one frame waits to push, next is lost
    for (k = 0; k < `FIFO_DEPTH; k++)
      send({4'h8, k[3:0], 16'hFFFF - k[15:0]});
    send(24'h80_0000);
    send(24'h80_0001);
    `CHK("drops", 32'h0000_0001, n_drop)
    for (k = 0; k < `FIFO_DEPTH; k++)
      take({4'h8, k[3:0]}, 16'hFFFF - k[15:0]);
    take(8'h80, 16'h0000);
    no_cmd();
    $display("test fill done");
    send(24'h40_5555);
    no_cmd();
    send(24'h70_AAAA);
    take(8'h70, 16'hAAAA);
    $display("test address done");
    fork
      send(24'h80_1111);
      begin
        repeat (40) @(posedge clk_i);
        req_abort <= 1'b1;
      end
    join
    req_abort <= 1'b0;
    no_cmd();
    `CHK("aborts", 32'h0000_0001, n_abort)
    send(24'h81_2222);
    take(8'h81, 16'h2222);
    $display("test abort done");
    en_b <= 1'b1;
    send(24'h82_3333);
    no_cmd();
    en_b <= 1'b0;
    send(24'h83_0000);
    take(8'h83, 16'h0000);
    $display("test enable done");
    finish_test();
  end

  initial begin
    repeat (12000) @(posedge clk_i);
    bad_count++;
    finish_test();
  end
endmodule
